/* File: hw/sram_burst_pkg.sv */
// constants, field layouts and carrier types for the burst/sleep control block
// assumes a 10 MHz clk_i and an AXI4-Lite master with 32-bit data
package sram_burst_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 20;
	localparam int BW_W    = 4;
	localparam int AXI_AW  = 8;
	localparam int AXI_DW  = 32;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [AXI_AW-1:0] CTRL_OFS   = 8'h00;
	localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h04;
	localparam logic [AXI_AW-1:0] ADDR_OFS   = 8'h08;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int CTRL_OVR_BIT   = 0;
	localparam int CTRL_ORDER_BIT = 1;
	localparam int CTRL_MODE_BIT  = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int STAT_ASLEEP_BIT  = 0;
	localparam int STAT_RECOVER_BIT = 1;
	localparam int STAT_ORDER_BIT   = 2;
	localparam int STAT_MODE_BIT    = 3;
	localparam int STAT_STATE_LSB   = 4;
	localparam int STAT_LOW_LSB     = 8;

	// ----------------------------------------------------------------
	// strap reset values: pull-up on output mode, pull-down on sleep
	// ----------------------------------------------------------------
	localparam logic ORDER_RST = 1'b0;
	localparam logic MODE_RST  = 1'b1;
	localparam logic SLEEP_RST = 1'b0;

	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 100;
	localparam int SLEEP_RECOVERY_NS = 200;
	localparam int SLEEP_RECOVERY_CYC_I =
		(SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SLEEP_RECOVERY_CYC = SLEEP_RECOVERY_CYC_I[7:0];

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              clk_en_n;
		logic              chip_select_first_n;
		logic              chip_select_second;
		logic              chip_select_third_n;
		logic              write_n;
		logic [BW_W-1:0]   byte_write_n;
		logic              burst_step_or_load;
		logic [ADDR_W-1:0] addr;
	} sram_cmd_t;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [BW_W-1:0]   byte_write_n;
		logic [ADDR_W-1:0] addr;
	} core_access_t;

	typedef enum logic [2:0] {
		ST_DESEL = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} ctrl_state_t;

endpackage

/* File: hw/burst_counter.sv */
// two-bit burst address sequencer, linear or interleaved
// assumes load and step are never high together
`timescale 1ns/100ps
`default_nettype none
module burst_counter (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// control
	input  wire logic       load_i,
	input  wire logic       step_i,
	input  wire logic [1:0] start_i,
	input  wire logic       interleave_i,
	// sequence
	output logic      [1:0] low_o
);
	logic [1:0] start_r;
	logic [1:0] count_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_r <= 2'h0;
			count_r <= 2'h0;
		end else if (load_i) begin
			start_r <= start_i;
			count_r <= 2'h0;
		end else if (step_i) begin
			// natural 2-bit wrap brings the fourth step back to the start
			count_r <= count_r + 2'h1;
		end
	end

	assign low_o = interleave_i ? (start_r ^ count_r) : (start_r + count_r);
endmodule
`default_nettype wire

/* File: hw/sram_burst_sleep_control.sv */
// burst, mode-strap and sleep control for a no-turnaround synchronous SRAM
// assumes the command bus is driven from logic on clk_i; straps and sleep are pins
//
// Behaviour
// - step high advances counter, uses its address
// - step low loads external burst start address
// - four addresses, fourth step returns to start
// - order strap low: linear low-bit sequence
// - mode strap low flow-through, high pipelined
// - sleep low active, high standby, default active
// - sleep after two cycles, state kept
// - asleep: deselected, inputs ignored, outputs off
// - sleep input is asynchronous and active high
// - hold cycle freezes both state machines; here a wake cycle still clears both, even during a hold
// - two-bit counter steps on every read or write continue, not on a deselect continue
// - continue shares controls; deselect continue needs deselect
// - begin read: enabled, selected, no write, load
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sram_burst_sleep_control
	import sram_burst_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// synchronous command bus from the memory controller
	input  wire sram_cmd_t         cmd_i,
	// strap and sleep pins
	input  wire logic              burst_order_strap_i,
	input  wire logic              output_mode_strap_i,
	input  wire logic              sleep_request_i,
	// toward the memory core and data pins
	output core_access_t           access_o,
	output logic                   dq_oe_o,
	output logic                   wr_data_take_o,
	output logic                   asleep_o,
	// AXI4-Lite write address
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// AXI4-Lite write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	// AXI4-Lite read data
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [AXI_DW-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [2:0]        pin_meta_r;
	logic [2:0]        pin_sync_r;
	logic              asleep;
	logic              asleep_d_r;
	logic              wake;
	logic [7:0]        recover_cnt_r;
	logic [2:0]        ctrl_r;
	logic              order_eff;
	logic              mode_eff;
	ctrl_state_t       state_r;
	ctrl_state_t       state_nxt;
	logic              hold;
	logic              selected;
	logic              do_load;
	logic              do_step;
	logic              rd_issue;
	logic              wr_issue;
	logic [1:0]        burst_low;
	logic [ADDR_W-1:0] base_addr_r;
	logic              access_rd_r;
	logic              access_wr_r;
	logic [BW_W-1:0]   access_bw_r;
	logic              access_live_r;
	logic              ft_oe_r;
	logic              pl_stage_r;
	logic              pl_oe_r;
	logic              ft_wr_r;
	logic              pl_wr1_r;
	logic              pl_wr2_r;
	logic              aw_take;
	logic              ar_take;
	logic [AXI_DW-1:0] rd_word;
	logic              rd_hit;

	// ----------------------------------------------------------------
	// pin synchronisers: order, mode, sleep
	// ----------------------------------------------------------------
	// sleep acts without regard to commands but is still sampled twice;
	// the two flops give the two-cycle entry latency
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta_r <= {SLEEP_RST, MODE_RST, ORDER_RST};
			pin_sync_r <= {SLEEP_RST, MODE_RST, ORDER_RST};
			asleep_d_r <= SLEEP_RST;
		end else begin
			pin_meta_r <= {sleep_request_i, output_mode_strap_i, burst_order_strap_i};
			pin_sync_r <= pin_meta_r;
			asleep_d_r <= pin_sync_r[2];
		end
	end

	assign asleep = pin_sync_r[2];
	assign wake   = asleep_d_r && !asleep;

	// recovery is only reported; keeping to read/deselect meanwhile is the controller's job
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			recover_cnt_r <= 8'h00;
		end else if (asleep) begin
			recover_cnt_r <= 8'h00;
		end else if (wake) begin
			recover_cnt_r <= SLEEP_RECOVERY_CYC;
		end else if (recover_cnt_r != 8'h00) begin
			recover_cnt_r <= recover_cnt_r - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// effective modes: software may override the straps
	// ----------------------------------------------------------------
	assign order_eff = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_ORDER_BIT] : pin_sync_r[0];
	assign mode_eff  = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_MODE_BIT] : pin_sync_r[1];

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	// asleep everything but the sleep pin is ignored
	assign hold     = cmd_i.clk_en_n || asleep;
	assign selected = !cmd_i.chip_select_first_n && cmd_i.chip_select_second
		&& !cmd_i.chip_select_third_n;

	always_comb begin
		state_nxt = state_r;
		do_load   = 1'b0;
		do_step   = 1'b0;
		rd_issue  = 1'b0;
		wr_issue  = 1'b0;
		if (!cmd_i.burst_step_or_load) begin
			if (selected && cmd_i.write_n) begin
				state_nxt = ST_READ;
				do_load   = 1'b1;
				rd_issue  = 1'b1;
			end else if (selected && (cmd_i.byte_write_n != {BW_W{1'b1}})) begin
				state_nxt = ST_WRITE;
				do_load   = 1'b1;
				wr_issue  = 1'b1;
			end else begin
				// deselect or write abort at begin of burst
				state_nxt = ST_DESEL;
			end
		end else begin
			// continue cycles ignore select and write_n alike; a write continue still reads byte_write_n
			unique case (state_r)
				ST_DESEL: state_nxt = ST_DESEL;
				ST_READ: begin
					do_step  = 1'b1;
					rd_issue = 1'b1;
				end
				ST_WRITE: begin
					do_step  = 1'b1;
					wr_issue = cmd_i.byte_write_n != {BW_W{1'b1}};
				end
				default: begin
					state_nxt = ST_DESEL;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read/write control state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_DESEL;
		end else if (wake) begin
			state_r <= ST_DESEL;
		end else if (!hold) begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// burst address
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_addr_r <= {ADDR_W{1'b0}};
		end else if (!hold && do_load) begin
			base_addr_r <= cmd_i.addr;
		end
	end

	burst_counter u_burst (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.load_i       (!hold && do_load),
		.step_i       (!hold && do_step),
		.start_i      (cmd_i.addr[1:0]),
		.interleave_i (order_eff),
		.low_o        (burst_low)
	);

	// ----------------------------------------------------------------
	// access strobes toward the core, one cycle each
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			access_rd_r   <= 1'b0;
			access_wr_r   <= 1'b0;
			access_bw_r   <= {BW_W{1'b1}};
			access_live_r <= 1'b0;
		end else begin
			access_rd_r   <= !hold && rd_issue;
			access_wr_r   <= !hold && wr_issue;
			access_live_r <= !hold && (rd_issue || wr_issue);
			if (!hold) begin
				access_bw_r <= cmd_i.byte_write_n;
			end
		end
	end

	// address shows the counter value after the load or step edge
	assign access_o.rd           = access_rd_r;
	assign access_o.wr           = access_wr_r;
	assign access_o.byte_write_n = access_bw_r;
	assign access_o.addr         = access_live_r ? {base_addr_r[ADDR_W-1:2], burst_low} : {ADDR_W{1'b0}};

	// ----------------------------------------------------------------
	// data I/O state: output enable and write data timing
	// ----------------------------------------------------------------
	// a hold keeps a driving read bus driving and a write bus released
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ft_oe_r    <= 1'b0;
			pl_stage_r <= 1'b0;
			pl_oe_r    <= 1'b0;
			ft_wr_r    <= 1'b0;
			pl_wr1_r   <= 1'b0;
			pl_wr2_r   <= 1'b0;
		end else if (wake || !hold) begin
			ft_oe_r    <= !wake && rd_issue;
			pl_stage_r <= !wake && rd_issue;
			pl_oe_r    <= !wake && pl_stage_r;
			ft_wr_r    <= !wake && wr_issue;
			pl_wr1_r   <= !wake && wr_issue;
			pl_wr2_r   <= !wake && pl_wr1_r;
		end
	end

	assign dq_oe_o        = !asleep && (mode_eff ? pl_oe_r : ft_oe_r);
	assign wr_data_take_o = !hold && (mode_eff ? pl_wr2_r : ft_wr_r);
	assign asleep_o       = asleep;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// address and data are taken together; costs nothing for a register file
	assign aw_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = aw_take;
	assign s_axi_wready  = aw_take;
	assign ar_take       = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= CTRL_RST;
		end else if (aw_take && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0]) begin
			ctrl_r <= s_axi_wdata[2:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (aw_take) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (s_axi_awaddr == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		rd_word = {AXI_DW{1'b0}};
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			CTRL_OFS: rd_word[2:0] = ctrl_r;
			STATUS_OFS: begin
				rd_word[STAT_ASLEEP_BIT]                  = asleep;
				rd_word[STAT_RECOVER_BIT]                 = recover_cnt_r != 8'h00;
				rd_word[STAT_ORDER_BIT]                   = order_eff;
				rd_word[STAT_MODE_BIT]                    = mode_eff;
				rd_word[STAT_STATE_LSB+2:STAT_STATE_LSB]  = state_r;
				rd_word[STAT_LOW_LSB+1:STAT_LOW_LSB]      = burst_low;
			end
			ADDR_OFS: rd_word[ADDR_W-1:0] = {base_addr_r[ADDR_W-1:2], burst_low};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= {AXI_DW{1'b0}};
			s_axi_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: tb/sram_burst_monitor.sv */
// port checks for the burst/sleep control block
// assumes one clk_i domain; bound onto the block by the statement at the foot
`timescale 1ns/100ps
`default_nettype none
module sram_burst_monitor
	import sram_burst_pkg::*;
(
	// clock and reset
	input wire logic         clk_i,
	input wire logic         rst_n_i,
	// pins
	input wire sram_cmd_t    cmd_i,
	input wire logic         sleep_request_i,
	// core side
	input wire core_access_t access_o,
	input wire logic         dq_oe_o,
	input wire logic         wr_data_take_o,
	input wire logic         asleep_o
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic take;
	logic cont;
	logic acc;
	assign take = !cmd_i.clk_en_n && !asleep_o;
	assign cont = take && cmd_i.burst_step_or_load;
	assign acc  = access_o.rd || access_o.wr;
	AST_BEGIN_READ: assert property (
		take && !cmd_i.burst_step_or_load && cmd_i.write_n && !cmd_i.chip_select_first_n
		&& cmd_i.chip_select_second && !cmd_i.chip_select_third_n
		|=> access_o.rd && access_o.addr == $past(cmd_i.addr))
		else $error("begin read not issued at the loaded address");
	AST_READ_STEP: assert property (
		access_o.rd && cont |=> access_o.rd && access_o.addr[ADDR_W-1:2] == $past(access_o.addr[ADDR_W-1:2])
		&& access_o.addr[1:0] != $past(access_o.addr[1:0]))
		else $error("read continue did not step the burst address");
	AST_WRITE_STEP: assert property (
		access_o.wr && cont && !(&cmd_i.byte_write_n) |=> access_o.wr
		&& access_o.addr[1:0] != $past(access_o.addr[1:0]))
		else $error("write continue did not step the burst address");
	AST_HOLD_IDLE: assert property (cmd_i.clk_en_n |=> !acc)
		else $error("access issued after a hold cycle");
	AST_HOLD_NO_TAKE: assert property (cmd_i.clk_en_n |-> !wr_data_take_o)
		else $error("write data taken in a hold cycle");
	AST_SLEEP_IDLE: assert property (asleep_o |=> !acc)
		else $error("access issued while asleep");
	AST_SLEEP_OUT: assert property (asleep_o |-> !dq_oe_o && !wr_data_take_o)
		else $error("data pins active while asleep");
	AST_SLEEP_ENTRY: assert property (sleep_request_i [*3] |=> asleep_o)
		else $error("sleep not entered two cycles after request");
	AST_AWAKE: assert property (!sleep_request_i [*3] |=> !asleep_o)
		else $error("asleep without a sleep request");
	COV_BURST: cover property (access_o.rd ##1 access_o.rd);
	COV_SLEEP: cover property ($rose(asleep_o));
	COV_HOLD: cover property (cmd_i.clk_en_n ##2 access_o.rd);
endmodule
bind sram_burst_sleep_control sram_burst_monitor u_sram_burst_monitor (.clk_i, .rst_n_i, .cmd_i,
	.sleep_request_i, .access_o, .dq_oe_o, .wr_data_take_o, .asleep_o);
`default_nettype wire

/* File: tb/ctrl_model.sv */
// memory controller model: drives the command bus and the sleep pin
// assumes one caller at a time; every change follows a rising edge
`timescale 1ns/100ps
`default_nettype none
module ctrl_model
	import sram_burst_pkg::*;
(
	input  wire logic clk_i,
	output sram_cmd_t cmd_o,
	output logic      sleep_request_o
);
	// ----------------------------------------------------------------
	// command cycles
	// ----------------------------------------------------------------
	initial begin
		cmd_o = '0;
		cmd_o.byte_write_n = 4'hF;
		sleep_request_o = 1'b0;
	end
	task automatic drive(input logic ce_n, input logic sel, input logic wr_n, input logic step,
		input logic [3:0] bw, input logic [ADDR_W-1:0] a);
		@(posedge clk_i);
		cmd_o.clk_en_n            <= ce_n;
		cmd_o.chip_select_first_n <= !sel;
		cmd_o.chip_select_second  <= sel;
		cmd_o.chip_select_third_n <= !sel;
		cmd_o.write_n             <= wr_n;
		cmd_o.byte_write_n        <= bw;
		cmd_o.burst_step_or_load  <= step;
		cmd_o.addr                <= a;
	endtask
	task automatic begin_rd(input logic [ADDR_W-1:0] a);
		drive(1'b0, 1'b1, 1'b1, 1'b0, 4'hF, a);
	endtask
	task automatic begin_wr(input logic [ADDR_W-1:0] a, input logic [3:0] bw);
		drive(1'b0, 1'b1, 1'b0, 1'b0, bw, a);
	endtask
	// ignored lines toggle so a stale value never passes for a real one
	task automatic cont(input logic [3:0] bw);
		drive(1'b0, 1'b0, 1'b0, 1'b1, bw, ~cmd_o.addr);
	endtask
	task automatic hold();
		drive(1'b1, 1'b1, 1'b1, 1'b0, 4'hF, ~cmd_o.addr);
	endtask
	task automatic idle(input int n);
		repeat (n) drive(1'b0, 1'b0, 1'b1, 1'b0, 4'hF, ~cmd_o.addr);
	endtask
	task automatic sleep_on();
		idle(2);
		sleep_request_o <= 1'b1;
	endtask
	task automatic sleep_off();
		idle(1);
		sleep_request_o <= 1'b0;
		idle(4 + int'(SLEEP_RECOVERY_CYC));
	endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the burst/sleep control block
// assumes ctrl_model on the command bus and the monitor bound in its own file
`timescale 1ns/100ps
`default_nettype none
module testbench
	import sram_burst_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic              clk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	logic              order_strap = ORDER_RST;
	logic              mode_strap = MODE_RST;
	sram_cmd_t         cmd;
	logic              sleep_req;
	core_access_t      access;
	logic              dq_oe, asleep, wr_take;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic [AXI_DW-1:0] wdata = '0, rdata, d;
	logic [3:0]        wstrb = 4'h0;
	logic [2:0]        prot = 3'h0;
	logic [1:0]        bresp, rresp, r;
	logic [ADDR_W-1:0] seen_q[$], exp_q[$];
	int                n_mismatch = 0, comparisons = 0, cycles = 0;
	always #50 clk_i = ~clk_i;
	ctrl_model u_ctrl_model (.clk_i(clk_i), .cmd_o(cmd), .sleep_request_o(sleep_req));
	sram_burst_sleep_control u_sram_burst_sleep_control (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
		.burst_order_strap_i(order_strap), .output_mode_strap_i(mode_strap), .sleep_request_i(sleep_req),
		.access_o(access), .dq_oe_o(dq_oe), .wr_data_take_o(wr_take), .asleep_o(asleep),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
	// sampled before the edge's updates land, so each pulse is seen once
	always @(posedge clk_i) begin
		cycles++;
		if (access.rd | access.wr) seen_q.push_back(access.addr);
		if (cycles == 3000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_q(input string what);
		cmp({what, " count"}, 32'(exp_q.size()), 32'(seen_q.size()));
		foreach (exp_q[i]) if (i < seen_q.size()) cmp(what, 32'(exp_q[i]), 32'(seen_q[i]));
		seen_q = {};
		exp_q = {};
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
		logic aw_on, w_on;
		@(posedge clk_i);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		aw_on = 1'b1;
		w_on = 1'b1;
		forever begin
			@(posedge clk_i);
			if (aw_on && awready) begin
				aw_on = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_on && wready) begin
				w_on = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk_i);
		{arvalid, rready} <= 2'h3;
		araddr <= a;
		forever begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		prot <= 3'h5;
		axi_rd(CTRL_OFS);
		cmp("ctrl reset", 32'h0, d);
		axi_rd(STATUS_OFS);
		cmp("status reset", 32'h0000_0018, d);
		axi_wr(CTRL_OFS, 32'h0000_0003);
		axi_rd(STATUS_OFS);
		cmp("override order and mode", 32'h0000_0004, d & 32'h0000_000C);
		axi_wr(CTRL_OFS, 32'h0000_0000, 4'hE);
		axi_rd(CTRL_OFS);
		cmp("ctrl kept without byte 0 strobe", 32'h0000_0003, d);
		axi_wr(STATUS_OFS, 32'h0000_00FF);
		cmp("status write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		axi_rd(8'h0C);
		cmp("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		axi_wr(CTRL_OFS, 32'h0);
		cmp("ctrl write resp", {30'h0, RESP_OKAY}, {30'h0, r});
		$display("register test done");
	endtask
	task automatic t_linear();
		u_ctrl_model.begin_rd(20'h12346);
		repeat (4) u_ctrl_model.cont(4'hF);
		u_ctrl_model.idle(3);
		exp_q = '{20'h12346, 20'h12347, 20'h12344, 20'h12345, 20'h12346};
		chk_q("linear read burst");
		$display("linear burst test done");
	endtask
	task automatic t_interleave_wr();
		@(posedge clk_i) order_strap <= 1'b1;
		u_ctrl_model.idle(3);
		u_ctrl_model.begin_wr(20'h00A51, 4'h0);
		u_ctrl_model.cont(4'h0);
		u_ctrl_model.cont(4'hF);
		u_ctrl_model.cont(4'h0);
		u_ctrl_model.cont(4'h0);
		u_ctrl_model.idle(3);
		exp_q = '{20'h00A51, 20'h00A50, 20'h00A52, 20'h00A51};
		chk_q("interleaved write burst");
		@(posedge clk_i) order_strap <= 1'b0;
		$display("interleaved write test done");
	endtask
	task automatic t_hold();
		u_ctrl_model.idle(3);
		u_ctrl_model.begin_rd(20'h00100);
		u_ctrl_model.hold();
		u_ctrl_model.hold();
		u_ctrl_model.cont(4'hF);
		u_ctrl_model.idle(3);
		exp_q = '{20'h00100, 20'h00101};
		chk_q("read across hold");
		$display("hold test done");
	endtask
	task automatic t_mode();
		for (int m = 0; m < 2; m++) begin
			@(posedge clk_i) mode_strap <= m[0];
			u_ctrl_model.idle(3);
			u_ctrl_model.begin_rd(20'h00040);
			u_ctrl_model.idle(1);
			#1 cmp("drive enable first cycle", {31'h0, !m[0]}, {31'h0, dq_oe});
			u_ctrl_model.idle(1);
			#1 cmp("drive enable second cycle", {31'h0, m[0]}, {31'h0, dq_oe});
			u_ctrl_model.begin_wr(20'h00044, 4'h0);
			u_ctrl_model.idle(1);
			#1 cmp("write take first cycle", {31'h0, !m[0]}, {31'h0, wr_take});
			u_ctrl_model.idle(1);
			#1 cmp("write take second cycle", {31'h0, m[0]}, {31'h0, wr_take});
		end
		u_ctrl_model.idle(2);
		seen_q = {};
		$display("output mode test done");
	endtask
	task automatic t_sleep();
		u_ctrl_model.begin_rd(20'h00201);
		u_ctrl_model.cont(4'hF);
		u_ctrl_model.idle(3);
		seen_q = {};
		u_ctrl_model.sleep_on();
		u_ctrl_model.idle(4);
		cmp("asleep", 32'h1, {31'h0, asleep});
		u_ctrl_model.begin_rd(20'h00300);
		u_ctrl_model.begin_rd(20'h00300);
		u_ctrl_model.idle(2);
		cmp("accesses while asleep", 32'h0, 32'(seen_q.size()));
		cmp("drive enable asleep", 32'h0, {31'h0, dq_oe});
		axi_rd(STATUS_OFS);
		cmp("status asleep", 32'h0000_0219, d);
		u_ctrl_model.sleep_off();
		cmp("awake", 32'h0, {31'h0, asleep});
		axi_rd(STATUS_OFS);
		cmp("status after wake", 32'h0000_0218, d);
		u_ctrl_model.cont(4'hF);
		u_ctrl_model.begin_rd(20'h00302);
		u_ctrl_model.idle(3);
		exp_q = '{20'h00302};
		chk_q("first access after wake");
		$display("sleep test done");
	endtask
	// ----------------------------------------------------------------
	// main sequence and verdict
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		u_ctrl_model.idle(4);
		t_regs();
		t_linear();
		t_interleave_wr();
		t_hold();
		t_mode();
		t_sleep();
		end_of_test();
	end
endmodule
`default_nettype wire
